// >>> src/twm_pkg.sv
// Constants and carrier types for the transceiver fabric word mapper.
// Assumes one channel, all logic on the channel parallel clock pclk.
// Function
// - 16-bit non-pipe transmit: force-disparity enables at bits 9 and 20.
// - 16-bit non-pipe transmit: disparity values at bits 10 and 21.
// - Pipe 16-bit transmit: electrical idle request on bits 10 and 21.
// - 20-bit transmit: low symbol bits 9:0, high symbol bits 20:11.
// - Receive word is 32 bits, layout set by width and mode.
// - 8-bit receive status layout only with 8B/10B and 8-bit width.
// - 8-bit receive: decoded data bits 7:0, control flag bit 8.
// - 8-bit receive: code violation on bit 9.
// - 8-bit receive: sync status bit 10, disparity error bit 11.
// - 8-bit receive: pattern detect on bit 12.
// - Non-pipe single width: rate-match delete bit 13, insert bit 14.
// - Pipe mode: bits 14:13 carry the two-bit pipe status.
// - Single width receive: running disparity on bit 15.
// - 10-bit receive: raw data 9:0, sync 10, disparity error 11, pattern 12.
// - 16-bit transmit: bytes at 7:0 and 18:11, control flags 8 and 19.
// - 16-bit receive: bytes at 7:0 and 23:16, flags repeated above.
package twm_pkg;

  // Word widths
  localparam int TX_W  = 22;
  localparam int RX_W  = 32;
  localparam int HALF  = 16;

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_RXMON = 8'h04;
  localparam logic [7:0] ADDR_TXMON = 8'h08;

  // Control register fields and reset value
  localparam int CTRL_WID  = 0;
  localparam int CTRL_PIPE = 2;
  localparam int CTRL_ENC  = 3;
  localparam logic [3:0] CTRL_RST = 4'h8;

  // Transmit word bit positions
  localparam int TX_CTL0 = 8;
  localparam int TX_FD0  = 9;
  localparam int TX_DV0  = 10;
  localparam int TX_HI   = 11;
  localparam int TX_CTL1 = 19;
  localparam int TX_FD1  = 20;
  localparam int TX_DV1  = 21;

  // Receive half-word bit positions
  localparam int RX_CTL  = 8;
  localparam int RX_ERR  = 9;
  localparam int RX_SYNC = 10;
  localparam int RX_DERR = 11;
  localparam int RX_PAT  = 12;
  localparam int RX_DEL  = 13;
  localparam int RX_INS  = 14;
  localparam int RX_RD   = 15;

  typedef enum logic [1:0] {
    TWM_W8  = 2'h0,
    TWM_W10 = 2'h1,
    TWM_W16 = 2'h2,
    TWM_W20 = 2'h3
  } twm_width_e;

  typedef struct packed {
    logic       enc;
    logic       pipe;
    twm_width_e width;
  } twm_cfg_s;

  typedef struct packed {
    logic [9:0] data;
    logic       ctrl;
    logic       fdisp;
    logic       dval;
  } twm_tx_lane_s;

  typedef struct packed {
    logic [9:0] data;
    logic       ctrl;
    logic       err;
    logic       sync;
    logic       disperr;
    logic       patdet;
    logic       rm_del;
    logic       rm_ins;
    logic [1:0] pipe_st;
    logic       rdisp;
  } twm_rx_lane_s;

endpackage

// >>> src/twm_mapper.sv
// Transceiver fabric word mapper: unpacks the 22-bit transmit word
// into per-symbol PCS fields and packs PCS receive status into the
// 32-bit receive word. Layout is chosen over APB.
// Assumes fabric and PCS both run on pclk; no synchronisers needed.
//
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module twm_mapper
  import twm_pkg::*;
(
  // Clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Fabric side
  input  wire logic [TX_W-1:0]      tx_word,
  output logic [RX_W-1:0]           rx_word,
  // PCS side
  output twm_tx_lane_s [1:0]        pcs_tx,
  output logic                      pcs_compliance,
  output logic                      pcs_elecidle,
  input  wire twm_rx_lane_s [1:0]   pcs_rx
);

  // Packs one symbol's receive status into a 16-bit half word
  function automatic logic [HALF-1:0] rx_half(
    input twm_rx_lane_s s,
    input logic         raw10,
    input logic         pipe
  );
    logic [HALF-1:0] h;
    h      = '0;
    h[7:0] = s.data[7:0];
    if (raw10) begin
      h[9:8] = s.data[9:8];
    end else begin
      h[RX_CTL] = s.ctrl;
      h[RX_ERR] = s.err;
    end
    h[RX_SYNC] = s.sync;
    h[RX_DERR] = s.disperr;
    h[RX_PAT]  = s.patdet;
    if (pipe) begin
      h[RX_INS:RX_DEL] = s.pipe_st;
    end else begin
      h[RX_DEL] = s.rm_del;
      h[RX_INS] = s.rm_ins;
    end
    h[RX_RD] = s.rdisp;
    return h;
  endfunction

  twm_cfg_s            cfg_r;
  twm_cfg_s            cfg_nxt;
  logic [31:0]         prdata_r;
  logic [31:0]         prdata_nxt;
  logic                err_r;
  logic                err_nxt;
  logic [TX_W-1:0]     txmon_r;
  twm_tx_lane_s [1:0]  tx_r;
  twm_tx_lane_s [1:0]  tx_nxt;
  logic                comp_r;
  logic                comp_nxt;
  logic                eidle_r;
  logic                eidle_nxt;
  logic [RX_W-1:0]     rx_r;
  logic [RX_W-1:0]     rx_nxt;
  logic                setup;
  logic                wr_ctrl;

  // APB phase decode; zero wait states
  assign setup   = psel & ~penable;
  assign wr_ctrl = psel & penable & pwrite & (paddr == ADDR_CTRL);
  assign pready  = psel & penable;
  assign pslverr = psel & penable & err_r;
  assign prdata  = prdata_r;

  // Register next values; read data captured in the setup cycle
  always_comb begin
    cfg_nxt    = cfg_r;
    prdata_nxt = prdata_r;
    err_nxt    = err_r;
    if (wr_ctrl) begin
      cfg_nxt.width = twm_width_e'(pwdata[CTRL_WID+1:CTRL_WID]);
      cfg_nxt.pipe  = pwdata[CTRL_PIPE];
      cfg_nxt.enc   = pwdata[CTRL_ENC];
    end
    if (setup) begin
      err_nxt    = 1'b0;
      prdata_nxt = 32'h0000_0000;
      case (paddr)
        ADDR_CTRL:  prdata_nxt = {28'h000_0000, cfg_r};
        ADDR_RXMON: prdata_nxt = rx_r;
        ADDR_TXMON: prdata_nxt = {10'h000, txmon_r};
        default:    err_nxt    = 1'b1;
      endcase
    end
  end

  // Register state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r    <= CTRL_RST;
      prdata_r <= 32'h0000_0000;
      err_r    <= 1'b0;
      txmon_r  <= '0;
    end else begin
      cfg_r    <= cfg_nxt;
      prdata_r <= prdata_nxt;
      err_r    <= err_nxt;
      txmon_r  <= tx_word;
    end
  end

  // Transmit unpacking; bits not in the layout stay zero at the PCS
  always_comb begin
    tx_nxt    = '0;
    comp_nxt  = 1'b0;
    eidle_nxt = 1'b0;
    case (cfg_r.width)
      TWM_W8: begin
        tx_nxt[0].data = {2'h0, tx_word[7:0]};
        if (cfg_r.enc) begin
          tx_nxt[0].ctrl = tx_word[TX_CTL0];
          if (cfg_r.pipe) begin
            comp_nxt  = tx_word[TX_FD0];
            eidle_nxt = tx_word[TX_DV0];
          end else begin
            tx_nxt[0].fdisp = tx_word[TX_FD0];
            tx_nxt[0].dval  = tx_word[TX_DV0];
          end
        end
      end
      TWM_W10: begin
        tx_nxt[0].data = tx_word[9:0];
      end
      TWM_W16: begin
        tx_nxt[0].data = {2'h0, tx_word[7:0]};
        tx_nxt[1].data = {2'h0, tx_word[TX_CTL1-1:TX_HI]};
        tx_nxt[0].ctrl = tx_word[TX_CTL0];
        tx_nxt[1].ctrl = tx_word[TX_CTL1];
        if (cfg_r.pipe) begin
          // Bit 20 is held low by the fabric and is not read
          comp_nxt  = tx_word[TX_FD0];
          // Both copies carry the same request; the low one is used
          eidle_nxt = tx_word[TX_DV0];
        end else begin
          tx_nxt[0].fdisp = tx_word[TX_FD0];
          tx_nxt[1].fdisp = tx_word[TX_FD1];
          tx_nxt[0].dval  = tx_word[TX_DV0];
          tx_nxt[1].dval  = tx_word[TX_DV1];
        end
      end
      TWM_W20: begin
        tx_nxt[0].data = tx_word[9:0];
        tx_nxt[1].data = tx_word[TX_FD1:TX_HI];
      end
      default: begin
        tx_nxt = '0;
      end
    endcase
  end

  // Receive packing; unused positions read zero
  always_comb begin
    rx_nxt = '0;
    case (cfg_r.width)
      TWM_W8: begin
        if (cfg_r.enc) begin
          rx_nxt[HALF-1:0] = rx_half(pcs_rx[0], 1'b0, cfg_r.pipe);
        end else begin
          rx_nxt[7:0] = pcs_rx[0].data[7:0];
        end
      end
      TWM_W10: begin
        rx_nxt[HALF-1:0] = rx_half(pcs_rx[0], 1'b1, cfg_r.pipe);
      end
      TWM_W16: begin
        rx_nxt = {rx_half(pcs_rx[1], 1'b0, cfg_r.pipe),
                  rx_half(pcs_rx[0], 1'b0, cfg_r.pipe)};
      end
      TWM_W20: begin
        rx_nxt = {rx_half(pcs_rx[1], 1'b1, cfg_r.pipe),
                  rx_half(pcs_rx[0], 1'b1, cfg_r.pipe)};
      end
      default: begin
        rx_nxt = '0;
      end
    endcase
  end

  // Datapath registers, one cycle of latency each way
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_r    <= '0;
      comp_r  <= 1'b0;
      eidle_r <= 1'b0;
      rx_r    <= '0;
    end else begin
      tx_r    <= tx_nxt;
      comp_r  <= comp_nxt;
      eidle_r <= eidle_nxt;
      rx_r    <= rx_nxt;
    end
  end

  assign pcs_tx         = tx_r;
  assign pcs_compliance = comp_r;
  assign pcs_elecidle   = eidle_r;
  assign rx_word        = rx_r;

  // Checks of the mapping, one cycle after the inputs
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_fd16;
    ($past(cfg_r.width) == TWM_W16) && !$past(cfg_r.pipe) |->
      pcs_tx[0].fdisp == $past(tx_word[9]) &&
      pcs_tx[1].fdisp == $past(tx_word[20]);
  endproperty
  a_fd16: assert property (p_fd16)
    else $error("force disparity enables misplaced");

  property p_comp16;
    ($past(cfg_r.width) == TWM_W16) && $past(cfg_r.pipe) |->
      pcs_compliance == $past(tx_word[9]) &&
      !pcs_tx[1].fdisp && !pcs_tx[0].fdisp;
  endproperty
  a_comp16: assert property (p_comp16)
    else $error("compliance request misplaced");

  property p_dv16;
    ($past(cfg_r.width) == TWM_W16) && !$past(cfg_r.pipe) |->
      pcs_tx[0].dval == $past(tx_word[10]) &&
      pcs_tx[1].dval == $past(tx_word[21]);
  endproperty
  a_dv16: assert property (p_dv16)
    else $error("disparity values misplaced");

  property p_eidle16;
    ($past(cfg_r.width) == TWM_W16) && $past(cfg_r.pipe) |->
      pcs_elecidle == $past(tx_word[10]) && !pcs_tx[1].dval;
  endproperty
  a_eidle16: assert property (p_eidle16)
    else $error("electrical idle misplaced");

  property p_tx20;
    ($past(cfg_r.width) == TWM_W20) |->
      {pcs_tx[1].data, pcs_tx[0].data} ==
      {$past(tx_word[20:11]), $past(tx_word[9:0])};
  endproperty
  a_tx20: assert property (p_tx20)
    else $error("20-bit transmit symbols misplaced");

  property p_tx16;
    ($past(cfg_r.width) == TWM_W16) |->
      pcs_tx[1].data[7:0] == $past(tx_word[18:11]) &&
      pcs_tx[1].ctrl == $past(tx_word[19]) &&
      pcs_tx[0].ctrl == $past(tx_word[8]);
  endproperty
  a_tx16: assert property (p_tx16)
    else $error("16-bit transmit bytes misplaced");

  property p_rx8;
    ($past(cfg_r.width) == TWM_W8) && $past(cfg_r.enc) |->
      rx_word[7:0] == $past(pcs_rx[0].data[7:0]) &&
      rx_word[8] == $past(pcs_rx[0].ctrl) &&
      rx_word[9] == $past(pcs_rx[0].err);
  endproperty
  a_rx8: assert property (p_rx8)
    else $error("8-bit receive data or control flag wrong");

  property p_rx8raw;
    ($past(cfg_r.width) == TWM_W8) && !$past(cfg_r.enc) |->
      rx_word[31:8] == 24'h00_0000;
  endproperty
  a_rx8raw: assert property (p_rx8raw)
    else $error("status layout used without decoding");

  property p_stat;
    ($past(cfg_r.width) != TWM_W8) || $past(cfg_r.enc) |->
      rx_word[12:10] == {$past(pcs_rx[0].patdet),
                         $past(pcs_rx[0].disperr),
                         $past(pcs_rx[0].sync)};
  endproperty
  a_stat: assert property (p_stat)
    else $error("sync, disparity or pattern flag wrong");

  property p_rm;
    !$past(cfg_r.pipe) && (($past(cfg_r.width) != TWM_W8) ||
      $past(cfg_r.enc)) |->
      rx_word[14:13] == {$past(pcs_rx[0].rm_ins),
                         $past(pcs_rx[0].rm_del)};
  endproperty
  a_rm: assert property (p_rm)
    else $error("rate match flags wrong");

  property p_pipe;
    $past(cfg_r.pipe) && (($past(cfg_r.width) != TWM_W8) ||
      $past(cfg_r.enc)) |->
      rx_word[14:13] == $past(pcs_rx[0].pipe_st);
  endproperty
  a_pipe: assert property (p_pipe)
    else $error("pipe status wrong");

  property p_rd;
    ($past(cfg_r.width) == TWM_W10) |->
      rx_word[15] == $past(pcs_rx[0].rdisp) &&
      rx_word[9:0] == $past(pcs_rx[0].data);
  endproperty
  a_rd: assert property (p_rd)
    else $error("10-bit receive layout wrong");

  property p_rx16;
    ($past(cfg_r.width) == TWM_W16) |->
      rx_word[23:16] == $past(pcs_rx[1].data[7:0]) &&
      rx_word[31] == $past(pcs_rx[1].rdisp) &&
      rx_word[24] == $past(pcs_rx[1].ctrl);
  endproperty
  a_rx16: assert property (p_rx16)
    else $error("16-bit receive upper half wrong");

  property p_zero;
    ($past(cfg_r.width) == TWM_W8) ||
    ($past(cfg_r.width) == TWM_W10) |->
      rx_word[31:16] == 16'h0000 && pcs_tx[1] == '0;
  endproperty
  a_zero: assert property (p_zero)
    else $error("unused bits not zero");

  property p_ctrl;
    wr_ctrl |=> cfg_r.pipe == $past(pwdata[CTRL_PIPE]) ##1
      pcs_elecidle == 1'b0 || cfg_r.pipe;
  endproperty
  a_ctrl: assert property (p_ctrl)
    else $error("control write not taken");

endmodule
`default_nettype wire

// >>> verif/twm_fabric_model.sv
// Fabric-side partner: packs per-symbol transmit fields into the
// 22-bit transmit word for the layout selected in cfg.
// Assumes the bench supplies fields and filler for unused bits.
`timescale 1ns/1ps
`default_nettype none
module twm_fabric_model
  import twm_pkg::*;
(
  // Layout and fields
  input  wire twm_cfg_s           cfg,
  input  wire twm_tx_lane_s [1:0] ln,
  input  wire logic               comp,
  input  wire logic               idle,
  // Filler for unassigned bits, never a stale copy
  input  wire logic [TX_W-1:0]    junk,
  // Word to the mapper
  output logic [TX_W-1:0]         tx_word
);
  // Place fields; unused positions carry filler
  always_comb begin
    tx_word = junk;
    case (cfg.width)
      TWM_W8: begin
        tx_word[7:0] = ln[0].data[7:0];
        if (cfg.enc) begin
          tx_word[8]  = ln[0].ctrl;
          tx_word[9]  = cfg.pipe ? comp : ln[0].fdisp;
          tx_word[10] = cfg.pipe ? idle : ln[0].dval;
        end
      end
      TWM_W10: tx_word[9:0] = ln[0].data;
      TWM_W16: begin
        tx_word[7:0]   = ln[0].data[7:0];
        tx_word[8]     = ln[0].ctrl;
        tx_word[18:11] = ln[1].data[7:0];
        tx_word[19]    = ln[1].ctrl;
        tx_word[9]     = cfg.pipe ? comp : ln[0].fdisp;
        tx_word[20]    = cfg.pipe ? 1'b0 : ln[1].fdisp;
        tx_word[10]    = cfg.pipe ? idle : ln[0].dval;
        tx_word[21]    = cfg.pipe ? idle : ln[1].dval;
      end
      default: begin
        tx_word[9:0]   = ln[0].data;
        tx_word[20:11] = ln[1].data;
      end
    endcase
  end
endmodule
`default_nettype wire

// >>> verif/tb.sv
// Self-checking bench for the word mapper: APB set-up, then random
// streams in every layout compared against bench-side mappings.
// Assumes the fabric partner model and the package are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import twm_pkg::*;
  logic               pclk, presetn, psel, penable, pwrite, pready;
  logic               pslverr, comp, idle, er;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata, rx_word, rd, e;
  logic [TX_W-1:0]    tx_word, junk;
  twm_tx_lane_s [1:0] pcs_tx, ln;
  logic               pcs_compliance, pcs_elecidle;
  twm_rx_lane_s [1:0] pcs_rx;
  twm_cfg_s           cfg;
  logic [63:0]        v;
  logic [27:0]        m, t, x;
  int                 failures, samples_checked;
  logic [3:0]         modes [9] = '{4'h8, 4'hc, 4'h0, 4'h1, 4'h5,
                                    4'ha, 4'he, 4'h3, 4'h7};

  twm_mapper u_twm_mapper (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_word(tx_word), .rx_word(rx_word), .pcs_tx(pcs_tx),
    .pcs_compliance(pcs_compliance), .pcs_elecidle(pcs_elecidle),
    .pcs_rx(pcs_rx));
  twm_fabric_model u_twm_fabric_model (.cfg(cfg), .ln(ln), .comp(comp),
    .idle(idle), .junk(junk), .tx_word(tx_word));

  // Expected receive half-word for one symbol
  function automatic logic [15:0] rx_half(twm_rx_lane_s s, logic raw,
                                          logic pipe);
    logic [15:0] h;
    h = '0;
    if (raw) begin
      h[9:0] = s.data;
    end else begin
      h[9:0] = {s.err, s.ctrl, s.data[7:0]};
    end
    h[12:10] = {s.patdet, s.disperr, s.sync};
    h[14:13] = pipe ? s.pipe_st : {s.rm_ins, s.rm_del};
    h[15] = s.rdisp;
    return h;
  endfunction

  // Expected receive word for a layout
  function automatic logic [31:0] rx_exp(twm_cfg_s c,
                                         twm_rx_lane_s [1:0] r);
    case (c.width)
      TWM_W8: return c.enc ? {16'h0, rx_half(r[0], 1'b0, c.pipe)}
                           : {24'h0, r[0].data[7:0]};
      TWM_W10: return {16'h0, rx_half(r[0], 1'b1, c.pipe)};
      TWM_W16: return {rx_half(r[1], 1'b0, c.pipe),
                       rx_half(r[0], 1'b0, c.pipe)};
      default: return {rx_half(r[1], 1'b1, c.pipe),
                       rx_half(r[0], 1'b1, c.pipe)};
    endcase
  endfunction

  // Transmit fields defined for a layout: {compliance, idle, lanes}
  function automatic logic [27:0] tx_mask(twm_cfg_s c);
    twm_tx_lane_s [1:0] k;
    k = '0;
    case (c.width)
      TWM_W8: k[0] = {10'h0ff, c.enc, {2{c.enc & ~c.pipe}}};
      TWM_W10: k[0].data = 10'h3ff;
      TWM_W16: begin
        k[0] = c.pipe ? 13'h7fc : 13'h7ff;
        k[1] = k[0];
      end
      default: k = {13'h1ff8, 13'h1ff8};
    endcase
    return {{2{c.pipe & c.enc}}, k};
  endfunction

  // Compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer, held until pready is sampled high; the watchdog
  // is the only limit on the wait
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Select a layout and stream random traffic through it
  task automatic run_cfg(input logic [3:0] c);
    apb(1'b1, ADDR_CTRL, {28'h0, c});
    apb(1'b0, ADDR_CTRL, 32'h0);
    check(rd, {28'h0, c});
    cfg <= c;
    repeat (40) begin
      @(posedge pclk);
      v = {$urandom, $urandom};
      pcs_rx <= v[39:0];
      v = {$urandom, $urandom};
      ln <= v[25:0];
      comp <= v[26];
      idle <= v[27];
      junk <= v[49:28];
      @(posedge pclk);
      #1;
      e = rx_exp(cfg, pcs_rx);
      check({19'h0, rx_word[12:0]}, {19'h0, e[12:0]});
      check({29'h0, rx_word[15:13]}, {29'h0, e[15:13]});
      check({16'h0, rx_word[31:16]}, {16'h0, e[31:16]});
      m = tx_mask(cfg);
      t = {pcs_compliance, pcs_elecidle, pcs_tx} & m;
      x = {comp, idle, ln} & m;
      check({6'h0, t[25:0]}, {6'h0, x[25:0]});
      check({30'h0, t[27:26]}, {30'h0, x[27:26]});
    end
    apb(1'b0, ADDR_RXMON, 32'h0);
    check(rd, rx_exp(cfg, pcs_rx));
    apb(1'b0, ADDR_TXMON, 32'h0);
    check(rd, {10'h0, tx_word});
    $display("test layout %h done", c);
  endtask

  task automatic report_and_stop;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // Watchdog against a hung transfer
  initial begin
    #100000;
    failures++;
    report_and_stop;
  end

  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {comp, idle, junk, ln, pcs_rx} = '0;
    cfg = CTRL_RST;
    failures = 0;
    samples_checked = 0;
    void'($urandom(32'h4d79d129));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ADDR_CTRL, 32'h0);
    check(rd, {28'h0, CTRL_RST});
    apb(1'b1, 8'h10, 32'h3);
    check({31'h0, er}, 32'h1);
    apb(1'b0, 8'h10, 32'h0);
    check(rd, 32'h0);
    check({31'h0, er}, 32'h1);
    apb(1'b1, ADDR_RXMON, 32'h3);
    check({31'h0, er}, 32'h0);
    apb(1'b0, ADDR_CTRL, 32'h0);
    check(rd, {28'h0, CTRL_RST});
    $display("test registers done");
    for (int k = 0; k < 9; k++) begin
      run_cfg(modes[k]);
    end
    report_and_stop;
  end
endmodule
`default_nettype wire
